//--- design/lcm_monitor.sv
// Light curtain monitor with muting, override and diagnostic code.
// Assumes sensor pins are asynchronous and configuration ports are static.
`timescale 1ns/10ps
`default_nettype none
module lcm_monitor
  import lcm_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = LCM_TICK_CYCLES,
  parameter int TIMER_WIDTH = LCM_TIMER_WIDTH
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // Curtain channels and muting sensors
  input wire logic CURTAIN_CHANNEL_ONE,
  input wire logic CURTAIN_CHANNEL_TWO,
  input wire logic GROUP_A_SENSOR_ONE,
  input wire logic GROUP_A_SENSOR_TWO,
  input wire logic GROUP_B_SENSOR_ONE,
  input wire logic GROUP_B_SENSOR_TWO,
  // Operator inputs
  input wire logic OVERRIDE_REQUEST,
  input wire logic RESET_REQUEST,
  input wire logic BLOCK_ENABLE,
  // Configuration
  input wire lcm_start_t START_MODE,
  input wire logic STARTUP_TEST,
  input wire lcm_sensor_t SENSOR_MODE,
  input wire logic [TIMER_WIDTH-1:0] DISCREPANCY_TIME,
  input wire logic [TIMER_WIDTH-1:0] MUTING_TIME,
  input wire logic [TIMER_WIDTH-1:0] SYNC_TIME,
  input wire logic [TIMER_WIDTH-1:0] OVERRIDE_RELEASE_TIME,
  // Contacts
  output logic SAFETY_ENABLE_OUT,
  output logic MUTING_ACTIVE_OUT,
  output logic ERROR_OUT,
  // Timer values and diagnostics
  output logic [TIMER_WIDTH-1:0] DISCREPANCY_TIMER_VALUE,
  output logic [TIMER_WIDTH-1:0] MUTING_TIMER_VALUE,
  output logic [TIMER_WIDTH-1:0] SYNC_TIMER_VALUE,
  output logic [TIMER_WIDTH-1:0] OVERRIDE_TIMER_VALUE,
  output logic [15:0] DIAGNOSTIC_CODE
);
  localparam int TCW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TCW-1:0] TICK_LAST = TCW'(TICK_CYCLES - 1);

  if (TICK_CYCLES < 1 || TIMER_WIDTH < 2) begin : g_chk
    $error("Tick length or timer width out of range");
  end

  typedef struct packed {
    logic [LCM_IN_WIDTH-1:0] sync1;
    logic [LCM_IN_WIDTH-1:0] sync2;
    logic [TCW-1:0] tick_cnt;
    logic tick;
    logic rst_prev;
    logic ovr_prev;
    lcm_state_t state;
    logic [15:0] err_code;
    logic qs;
    logic qm;
    logic er;
    logic [15:0] diag;
  } lcm_mon_state_t;

  lcm_mon_state_t cur;
  lcm_mon_state_t nx;

  lcm_timer_if #(.W(TIMER_WIDTH)) disc_if ();
  lcm_timer_if #(.W(TIMER_WIDTH)) mute_if ();
  lcm_timer_if #(.W(TIMER_WIDTH)) sync_if ();
  lcm_timer_if #(.W(TIMER_WIDTH)) ovr_if ();

  logic [LCM_IN_WIDTH-1:0] raw;
  logic [1:0] ch;
  logic [3:0] sens;
  logic en;
  logic rst;
  logic ovr;
  logic mute_ok;
  logic [3:0] start_mask;
  lcm_state_t restart_state;

  assign raw = {BLOCK_ENABLE, RESET_REQUEST, OVERRIDE_REQUEST,
                GROUP_B_SENSOR_TWO, GROUP_B_SENSOR_ONE,
                GROUP_A_SENSOR_TWO, GROUP_A_SENSOR_ONE,
                CURTAIN_CHANNEL_TWO, CURTAIN_CHANNEL_ONE};
  assign ch = {cur.sync2[LCM_IN_CH2], cur.sync2[LCM_IN_CH1]};
  assign sens = {cur.sync2[LCM_IN_B2], cur.sync2[LCM_IN_B1],
                 cur.sync2[LCM_IN_A2], cur.sync2[LCM_IN_A1]};
  assign en = cur.sync2[LCM_IN_EN];
  assign rst = cur.sync2[LCM_IN_RST];
  assign ovr = cur.sync2[LCM_IN_OVR];

  // Group agreement that lets muting begin or hold
  always_comb begin
    if (SENSOR_MODE == LCM_TWO_SENSOR_PARALLEL ||
        SENSOR_MODE == LCM_TWO_SENSOR_SERIAL) begin
      mute_ok = sens[0] & sens[1];
    end else begin
      mute_ok = (sens[0] & sens[1]) | (sens[2] & sens[3]);
    end
  end

  // Sensors allowed to pick up first; two-sensor serial fixes the direction, four-sensor sequential allows A1 or B2
  always_comb begin
    case (SENSOR_MODE)
      LCM_TWO_SENSOR_SERIAL: start_mask = 4'h1;
      LCM_FOUR_SENSOR_SEQUENTIAL: start_mask = 4'h9;
      default: start_mask = 4'hF;
    endcase
  end

  // Automatic start skips the reset handshake
  assign restart_state = (START_MODE == LCM_AUTO_START_MODE) ?
    ST_CLEAR : ST_WAIT_RST_RISE;

  // Timer supervision windows
  assign disc_if.run = (cur.state == ST_WAIT_SECOND) ||
                       (cur.state == ST_ONE_OPEN);
  assign disc_if.limit = DISCREPANCY_TIME;
  assign mute_if.run = (cur.state == ST_MUTE_ACTIVE) ||
                       (cur.state == ST_MOVE_CLEAR);
  assign mute_if.limit = MUTING_TIME;
  assign sync_if.run = (cur.state == ST_MUTE_SYNC) ||
                       (cur.state == ST_MOVE_CLEAR);
  assign sync_if.limit = SYNC_TIME;
  assign ovr_if.run = (cur.state == ST_OVERRIDE);
  assign ovr_if.limit = OVERRIDE_RELEASE_TIME;

  lcm_timer #(.W(TIMER_WIDTH)) u_disc (
    .clk(REF_CLK), .rst_n(RESETN), .tick(cur.tick), .tmr(disc_if));
  lcm_timer #(.W(TIMER_WIDTH)) u_mute (
    .clk(REF_CLK), .rst_n(RESETN), .tick(cur.tick), .tmr(mute_if));
  lcm_timer #(.W(TIMER_WIDTH)) u_sync (
    .clk(REF_CLK), .rst_n(RESETN), .tick(cur.tick), .tmr(sync_if));
  lcm_timer #(.W(TIMER_WIDTH)) u_ovr (
    .clk(REF_CLK), .rst_n(RESETN), .tick(cur.tick), .tmr(ovr_if));

  always_comb begin
    nx = cur;
    nx.sync1 = raw;
    nx.sync2 = cur.sync1;
    nx.rst_prev = rst;
    nx.ovr_prev = ovr;
    // Common tick for all four timers
    if (cur.tick_cnt == TICK_LAST) begin
      nx.tick_cnt = '0;
      nx.tick = 1'b1;
    end else begin
      nx.tick_cnt = cur.tick_cnt + {{(TCW-1){1'b0}}, 1'b1};
      nx.tick = 1'b0;
    end
    if (!en) begin
      nx.state = ST_DISABLED;
      nx.err_code = LCM_DG_NO_ENABLE;
    end else begin
      case (cur.state)
        ST_DISABLED: begin
          if (rst && ch == 2'b11) begin
            nx.state = ST_ERROR;
            nx.err_code = LCM_ERR_STARTUP;
          end else if (STARTUP_TEST) begin
            nx.state = ST_STARTUP_TEST;
          end else begin
            nx.state = ST_WAIT_FIRST;
          end
        end
        ST_STARTUP_TEST: begin
          // The curtain must be seen interrupted before a start
          if (ch == 2'b00) begin
            nx.state = ST_WAIT_FIRST;
          end
        end
        ST_WAIT_FIRST: begin
          if (ch == 2'b11) begin
            nx.state = restart_state;
          end else if (ch != 2'b00) begin
            nx.state = ST_WAIT_SECOND;
          end
        end
        ST_WAIT_SECOND: begin
          if (ch == 2'b11) begin
            nx.state = restart_state;
          end else if (ch == 2'b00) begin
            nx.state = ST_ERROR;
            nx.err_code = LCM_ERR_ONE_CHANNEL;
          end else if (disc_if.expired) begin
            nx.state = ST_ERROR;
            nx.err_code = LCM_ERR_DISCREPANCY;
          end
        end
        ST_WAIT_RST_RISE: begin
          if (ch != 2'b11) begin
            nx.state = ST_WAIT_FIRST;
          end else if (rst && !cur.rst_prev) begin
            nx.state = ST_WAIT_RST_FALL;
          end
        end
        ST_WAIT_RST_FALL: begin
          if (ch != 2'b11) begin
            nx.state = ST_WAIT_FIRST;
          end else if (!rst && cur.rst_prev) begin
            nx.state = ST_CLEAR;
          end
        end
        ST_CLEAR: begin
          if (ch == 2'b00) begin
            nx.state = ST_WAIT_FIRST;
          end else if (ch != 2'b11) begin
            nx.state = ST_ONE_OPEN;
          end else if ((sens & ~start_mask) != 4'h0) begin
            nx.state = ST_ERROR;
            nx.err_code = LCM_ERR_ORDER;
          end else if (sens != 4'h0) begin
            nx.state = ST_MUTE_SYNC;
          end
        end
        ST_ONE_OPEN: begin
          if (ch == 2'b11) begin
            nx.state = ST_ERROR;
            nx.err_code = LCM_ERR_ONE_CHANNEL;
          end else if (ch == 2'b00) begin
            nx.state = ST_WAIT_FIRST;
          end else if (disc_if.expired) begin
            nx.state = ST_ERROR;
            nx.err_code = LCM_ERR_DISCREPANCY;
          end
        end
        ST_MUTE_SYNC: begin
          // Curtain blocked before muting is granted trips normally
          if (ch != 2'b11) begin
            nx.state = ST_WAIT_FIRST;
          end else if (sync_if.expired) begin
            nx.state = ST_ERROR;
            nx.err_code = LCM_ERR_SYNC;
          end else if (mute_ok) begin
            nx.state = ST_MUTE_ACTIVE;
          end else if (sens == 4'h0) begin
            nx.state = ST_CLEAR;
          end
        end
        ST_MUTE_ACTIVE: begin
          if (mute_if.expired) begin
            nx.state = ST_ERROR;
            nx.err_code = LCM_ERR_MUTING;
          end else if (!mute_ok) begin
            nx.state = ST_MOVE_CLEAR;
          end
        end
        ST_MOVE_CLEAR: begin
          if (mute_if.expired) begin
            nx.state = ST_ERROR;
            nx.err_code = LCM_ERR_MUTING;
          end else if (sens == 4'h0) begin
            if (ch == 2'b11) begin
              nx.state = ST_CLEAR;
            end else begin
              nx.state = ST_ERROR;
              nx.err_code = LCM_ERR_NOT_FREE;
            end
          end else if (sync_if.expired) begin
            nx.state = ST_ERROR;
            nx.err_code = LCM_ERR_SYNC;
          end else if (mute_ok) begin
            nx.state = ST_MUTE_ACTIVE;
          end
        end
        ST_OVERRIDE: begin
          if (ovr_if.expired) begin
            nx.state = ST_ERROR;
            nx.err_code = LCM_ERR_OVERRIDE;
          end else if (sens == 4'h0 && ch == 2'b11) begin
            nx.state = restart_state;
          end else if (!ovr) begin
            nx.state = ST_ERROR;
            nx.err_code = LCM_ERR_CLEARING;
          end
        end
        ST_ERROR: begin
          // Only muting faults may be bridged, and only with a time set
          if (ovr && !cur.ovr_prev && OVERRIDE_RELEASE_TIME != '0 &&
              (cur.err_code == LCM_ERR_MUTING ||
               cur.err_code == LCM_ERR_SYNC ||
               cur.err_code == LCM_ERR_ORDER ||
               cur.err_code == LCM_ERR_NOT_FREE)) begin
            nx.state = ST_OVERRIDE;
          end else if (rst && !cur.rst_prev) begin
            nx.state = ST_WAIT_FIRST;
          end
        end
        default: begin
          nx.state = ST_DISABLED;
        end
      endcase
    end
    // Contacts and code follow the next state so they change with it
    nx.qs = 1'b0;
    nx.qm = 1'b0;
    nx.er = 1'b0;
    case (nx.state)
      ST_DISABLED: nx.diag = LCM_DG_NO_ENABLE;
      ST_STARTUP_TEST: nx.diag = LCM_DG_STARTUP_TEST;
      ST_WAIT_FIRST: nx.diag = LCM_DG_WAIT_FIRST;
      ST_WAIT_SECOND: nx.diag = LCM_DG_WAIT_SECOND;
      ST_WAIT_RST_RISE: nx.diag = LCM_DG_WAIT_RST_RISE;
      ST_WAIT_RST_FALL: nx.diag = LCM_DG_WAIT_RST_FALL;
      ST_ONE_OPEN: nx.diag = LCM_DG_ONE_OPEN;
      ST_CLEAR: begin
        nx.diag = LCM_DG_CLEAR;
        nx.qs = 1'b1;
      end
      ST_MUTE_SYNC: begin
        nx.diag = LCM_DG_MUTE_SYNC;
        nx.qs = 1'b1;
      end
      ST_MUTE_ACTIVE: begin
        nx.diag = LCM_DG_MUTE_ACTIVE;
        nx.qs = 1'b1;
        nx.qm = 1'b1;
      end
      ST_MOVE_CLEAR: begin
        nx.diag = LCM_DG_MOVE_CLEAR;
        nx.qs = 1'b1;
        nx.qm = 1'b1;
      end
      ST_OVERRIDE: begin
        nx.diag = LCM_DG_OVERRIDE;
        nx.qs = 1'b1;
        nx.qm = 1'b1;
      end
      ST_ERROR: begin
        nx.diag = nx.err_code;
        nx.er = 1'b1;
      end
      default: nx.diag = LCM_DG_NO_ENABLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cur <= '0;
    end else begin
      cur <= nx;
    end
  end

  assign SAFETY_ENABLE_OUT = cur.qs;
  assign MUTING_ACTIVE_OUT = cur.qm;
  assign ERROR_OUT = cur.er;
  assign DIAGNOSTIC_CODE = cur.diag;
  assign DISCREPANCY_TIMER_VALUE = disc_if.value;
  assign MUTING_TIMER_VALUE = mute_if.value;
  assign SYNC_TIMER_VALUE = sync_if.value;
  assign OVERRIDE_TIMER_VALUE = ovr_if.value;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  AST_NO_ENABLE: assert property (
    !en |=> (DIAGNOSTIC_CODE == LCM_DG_NO_ENABLE) && !SAFETY_ENABLE_OUT)
    else $error("Disabled block shows wrong code or enable");
  AST_SECOND_WAIT: assert property (
    (cur.state == ST_WAIT_FIRST) && en && (ch == 2'b01) |=>
    (DIAGNOSTIC_CODE == LCM_DG_WAIT_SECOND))
    else $error("Single channel did not lead to second wait");
  AST_RESET_SEQ: assert property (
    (cur.state == ST_WAIT_RST_FALL) && en && (ch == 2'b11) &&
    !rst && cur.rst_prev |=> SAFETY_ENABLE_OUT &&
    (DIAGNOSTIC_CODE == LCM_DG_CLEAR))
    else $error("Reset fall did not release the enable");
  AST_CLEAR_CODE: assert property (
    (DIAGNOSTIC_CODE == LCM_DG_CLEAR) |->
    SAFETY_ENABLE_OUT && !MUTING_ACTIVE_OUT && !ERROR_OUT)
    else $error("Clear code without matching contacts");
  AST_DISC_EXPIRE: assert property (
    (cur.state == ST_WAIT_SECOND) && en && (ch ^ 2'b11) != 2'b00 &&
    (ch != 2'b00) && disc_if.expired |=>
    ERROR_OUT && (DIAGNOSTIC_CODE == LCM_ERR_DISCREPANCY))
    else $error("Discrepancy expiry not flagged");
  AST_OVR_LIMIT: assert property (
    (cur.state == ST_OVERRIDE) && en && ovr_if.expired |=>
    ERROR_OUT && !SAFETY_ENABLE_OUT &&
    (DIAGNOSTIC_CODE == LCM_ERR_OVERRIDE))
    else $error("Override outlived its release time");
  AST_MUTE_LIMIT: assert property (
    (cur.state == ST_MUTE_ACTIVE) && en && mute_if.expired |=>
    ERROR_OUT && !SAFETY_ENABLE_OUT &&
    (DIAGNOSTIC_CODE == LCM_ERR_MUTING))
    else $error("Muting time expiry not flagged");
  AST_SYNC_LIMIT: assert property (
    (cur.state == ST_MUTE_SYNC) && en && (ch == 2'b11) &&
    sync_if.expired |=> ERROR_OUT && !SAFETY_ENABLE_OUT)
    else $error("Sync expiry left enable on");
  AST_MUTE_OUT: assert property (
    MUTING_ACTIVE_OUT |-> SAFETY_ENABLE_OUT && !ERROR_OUT &&
    (DIAGNOSTIC_CODE[15:12] == 4'h8))
    else $error("Muting output outside a muting state");
  AST_ERR_OUT: assert property (
    ERROR_OUT |-> !SAFETY_ENABLE_OUT &&
    (DIAGNOSTIC_CODE[15:12] == LCM_ERR_CLASS))
    else $error("Error output without error code");

  COV_CLEAR: cover property (
    (DIAGNOSTIC_CODE == LCM_DG_WAIT_RST_FALL) ##1
    (DIAGNOSTIC_CODE == LCM_DG_CLEAR));
  COV_MUTING: cover property (
    MUTING_ACTIVE_OUT ##[1:100] (DIAGNOSTIC_CODE == LCM_DG_MOVE_CLEAR));
  COV_OVERRIDE: cover property (
    (DIAGNOSTIC_CODE == LCM_DG_OVERRIDE) && SAFETY_ENABLE_OUT);
  COV_ORDER_ERR: cover property (DIAGNOSTIC_CODE == LCM_ERR_ORDER);
endmodule
`default_nettype wire

//--- shared/lcm_pkg.sv
// Constants, state and mode types of the light curtain muting monitor.
// Assumes a single 100 MHz clock; all supervised times count in ticks.
`default_nettype none
package lcm_pkg;
  // Clock and common time base
  localparam int unsigned LCM_CLK_PERIOD_NS = 10;
  localparam int unsigned LCM_TICK_TIME_MS = 10;
  localparam int unsigned LCM_NS_PER_MS = 1000000;
  localparam int unsigned LCM_TICK_CYCLES =
    (LCM_TICK_TIME_MS * LCM_NS_PER_MS) / LCM_CLK_PERIOD_NS;
  localparam int LCM_TIMER_WIDTH = 16;
  // Positions of the pin inputs in the synchroniser vector
  localparam int LCM_IN_CH1 = 0;
  localparam int LCM_IN_CH2 = 1;
  localparam int LCM_IN_A1 = 2;
  localparam int LCM_IN_A2 = 3;
  localparam int LCM_IN_B1 = 4;
  localparam int LCM_IN_B2 = 5;
  localparam int LCM_IN_OVR = 6;
  localparam int LCM_IN_RST = 7;
  localparam int LCM_IN_EN = 8;
  localparam int LCM_IN_WIDTH = 9;
  // Diagnostic codes
  localparam logic [15:0] LCM_DG_NO_ENABLE = 16'h0000;
  localparam logic [15:0] LCM_DG_WAIT_FIRST = 16'h2001;
  localparam logic [15:0] LCM_DG_WAIT_SECOND = 16'h2002;
  localparam logic [15:0] LCM_DG_WAIT_RST_RISE = 16'h2003;
  localparam logic [15:0] LCM_DG_WAIT_RST_FALL = 16'h2004;
  localparam logic [15:0] LCM_DG_ONE_OPEN = 16'h2005;
  localparam logic [15:0] LCM_DG_STARTUP_TEST = 16'h200E;
  localparam logic [15:0] LCM_DG_CLEAR = 16'h8006;
  localparam logic [15:0] LCM_DG_MUTE_SYNC = 16'h8011;
  localparam logic [15:0] LCM_DG_MUTE_ACTIVE = 16'h8012;
  localparam logic [15:0] LCM_DG_MOVE_CLEAR = 16'h8018;
  localparam logic [15:0] LCM_DG_OVERRIDE = 16'h8020;
  localparam logic [15:0] LCM_ERR_DISCREPANCY = 16'hF001;
  localparam logic [15:0] LCM_ERR_MUTING = 16'hF003;
  localparam logic [15:0] LCM_ERR_SYNC = 16'hF004;
  localparam logic [15:0] LCM_ERR_OVERRIDE = 16'hF005;
  localparam logic [15:0] LCM_ERR_STARTUP = 16'hF00B;
  localparam logic [15:0] LCM_ERR_ONE_CHANNEL = 16'hF00E;
  localparam logic [15:0] LCM_ERR_ORDER = 16'hF019;
  localparam logic [15:0] LCM_ERR_NOT_FREE = 16'hF01A;
  localparam logic [15:0] LCM_ERR_CLEARING = 16'hF01B;
  localparam logic [3:0] LCM_ERR_CLASS = 4'hF;
  // Start modes and sensor arrangements
  typedef enum logic [1:0] {
    LCM_AUTO_START_MODE = 2'h0,
    LCM_MANUAL_START_MODE = 2'h1,
    LCM_CONTROLLED_START_MODE = 2'h2
  } lcm_start_t;
  typedef enum logic [1:0] {
    LCM_TWO_SENSOR_PARALLEL = 2'h0,
    LCM_TWO_SENSOR_SERIAL = 2'h1,
    LCM_FOUR_SENSOR_PARALLEL = 2'h2,
    LCM_FOUR_SENSOR_SEQUENTIAL = 2'h3
  } lcm_sensor_t;
  typedef enum logic [3:0] {
    ST_DISABLED = 4'h0,
    ST_STARTUP_TEST = 4'h1,
    ST_WAIT_FIRST = 4'h2,
    ST_WAIT_SECOND = 4'h3,
    ST_WAIT_RST_RISE = 4'h4,
    ST_WAIT_RST_FALL = 4'h5,
    ST_CLEAR = 4'h6,
    ST_ONE_OPEN = 4'h7,
    ST_MUTE_SYNC = 4'h8,
    ST_MUTE_ACTIVE = 4'h9,
    ST_MOVE_CLEAR = 4'hA,
    ST_OVERRIDE = 4'hB,
    ST_ERROR = 4'hC
  } lcm_state_t;
endpackage
`default_nettype wire

//--- shared/lcm_timer_if.sv
// Control and result of one supervision timer.
// Assumes controller and timer share one clock.
`timescale 1ns/10ps
`default_nettype none
interface lcm_timer_if #(parameter int W = 16);
  logic run;
  logic [W-1:0] limit;
  logic [W-1:0] value;
  logic expired;
  modport ctrl (output run, output limit, input value, input expired);
  modport timer (input run, input limit, output value, output expired);
endinterface
`default_nettype wire

//--- design/lcm_timer.sv
// One supervision timer counting common ticks while run is high.
// Assumes tick is a one-cycle pulse on the same clock.
`timescale 1ns/10ps
`default_nettype none
module lcm_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Time base
  input wire logic tick,
  // Control
  lcm_timer_if.timer tmr
);
  typedef struct packed {
    logic [W-1:0] value;
  } lcm_tmr_state_t;

  lcm_tmr_state_t cur;
  lcm_tmr_state_t nx;

  if (W < 2) begin : g_chk
    $error("Timer width too small");
  end

  always_comb begin
    nx = cur;
    if (!tmr.run) begin
      nx.value = '0;
    end else if (tick && (cur.value != {W{1'b1}})) begin
      nx.value = cur.value + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= nx;
    end
  end

  // A limit of zero means the supervision is switched off
  assign tmr.value = cur.value;
  assign tmr.expired = (tmr.limit != '0) && (cur.value >= tmr.limit);

  AST_TMR_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    !tmr.run |=> (tmr.value == '0))
    else $error("Timer not cleared after supervision ended");
endmodule
`default_nettype wire

//--- tb/lcm_sensor_model.sv
// Model of the curtain channels and muting sensors.
// Assumes the bench sets the scene just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module lcm_sensor_model (
  // Clock and scene
  input wire logic clk,
  input wire logic slow,
  input wire logic [5:0] scene,
  // Sensor lines: B2 B1 A2 A1 channel two, channel one
  output logic [5:0] lines
);
  logic [5:0] lag [0:3];
  // Slow contacts settle four cycles late
  always_ff @(posedge clk) begin
    lag[0] <= scene;
    for (int i = 1; i < 4; i++) begin
      lag[i] <= lag[i-1];
    end
  end
  assign lines = slow ? lag[3] : scene;
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Scenario bench for the light curtain muting monitor.
// Assumes the sensor model drives the six sensor pins.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import lcm_pkg::*;
  logic clk = 0, rstn = 0, ovr = 0, rreq = 0, en = 0, slow = 0;
  logic [5:0] scene = 6'h00;
  logic stup = 0;
  logic [15:0] mtime = 16'h0000;
  lcm_start_t smode = LCM_MANUAL_START_MODE;
  lcm_sensor_t sens_mode = LCM_TWO_SENSOR_PARALLEL;
  logic [5:0] ln;
  logic qs, qm, er;
  logic [15:0] dg, tq[4];
  int fails = 0, n_compared = 0;
  always #5 clk = ~clk;
  lcm_sensor_model u_lcm_sensor_model (.clk(clk), .slow(slow),
    .scene(scene), .lines(ln));
  // Short tick of four cycles keeps every supervised time at 32 cycles or less
  lcm_monitor #(.TICK_CYCLES(4)) u_lcm_monitor (.REF_CLK(clk),
    .RESETN(rstn), .CURTAIN_CHANNEL_ONE(ln[0]),
    .CURTAIN_CHANNEL_TWO(ln[1]), .GROUP_A_SENSOR_ONE(ln[2]),
    .GROUP_A_SENSOR_TWO(ln[3]), .GROUP_B_SENSOR_ONE(ln[4]),
    .GROUP_B_SENSOR_TWO(ln[5]), .OVERRIDE_REQUEST(ovr),
    .RESET_REQUEST(rreq), .BLOCK_ENABLE(en),
    .START_MODE(smode), .STARTUP_TEST(stup),
    .SENSOR_MODE(sens_mode),
    .DISCREPANCY_TIME(16'h0008), .MUTING_TIME(mtime),
    .SYNC_TIME(16'h0006), .OVERRIDE_RELEASE_TIME(16'h0003),
    .SAFETY_ENABLE_OUT(qs), .MUTING_ACTIVE_OUT(qm), .ERROR_OUT(er),
    .DISCREPANCY_TIMER_VALUE(tq[0]), .MUTING_TIMER_VALUE(tq[1]),
    .SYNC_TIMER_VALUE(tq[2]), .OVERRIDE_TIMER_VALUE(tq[3]),
    .DIAGNOSTIC_CODE(dg));
  task automatic final_report;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Bounded wait on the code; running out ends the run
  task automatic wt(logic [15:0] e);
    int i;
    for (i = 0; i < 200 && dg !== e; i++) @(posedge clk) #2;
    chk("code", e, dg);
    if (dg !== e) final_report();
  endtask
  task automatic put(logic [5:0] s, logic o, logic r);
    @(posedge clk) #1;
    scene = s;
    ovr = o;
    rreq = r;
  endtask
  task automatic t_start;
    @(posedge clk) #1;
    en = 1;
    wt(LCM_DG_WAIT_FIRST);
    put(6'h01, 0, 0);
    wt(LCM_DG_WAIT_SECOND);
    put(6'h03, 0, 0);
    wt(LCM_DG_WAIT_RST_RISE);
    put(6'h03, 0, 1);
    wt(LCM_DG_WAIT_RST_FALL);
    put(6'h03, 0, 0);
    wt(LCM_DG_CLEAR);
    chk("qs", 1, qs);
  endtask
  // Slow sensors: each step lands seven cycles after it is set
  task automatic t_mute;
    @(posedge clk) #1;
    slow = 1;
    put(6'h07, 0, 0);
    wt(LCM_DG_MUTE_SYNC);
    put(6'h0F, 0, 0);
    wt(LCM_DG_MUTE_ACTIVE);
    chk("qm", 1, qm);
    put(6'h0C, 0, 0);
    repeat (8) @(posedge clk) #2;
    chk("qs muted", 1, qs);
    put(6'h08, 0, 0);
    wt(LCM_DG_MOVE_CLEAR);
    put(6'h03, 0, 0);
    wt(LCM_DG_CLEAR);
    chk("qm", 0, qm);
    // Timer value clears one edge after the state leaves supervision
    @(posedge clk) #2;
    chk("sync timer", 0, tq[2]);
    @(posedge clk) #1;
    slow = 0;
  endtask
  task automatic t_sync_ovr;
    put(6'h07, 0, 0);
    wt(LCM_ERR_SYNC);
    chk("sync timer", 16'h0006, tq[2]);
    chk("er", 1, er);
    chk("qs", 0, qs);
    put(6'h07, 1, 0);
    wt(LCM_DG_OVERRIDE);
    chk("qs ovr", 1, qs);
    wt(LCM_ERR_OVERRIDE);
    chk("ovr timer", 16'h0003, tq[3]);
    put(6'h00, 0, 1);
    wt(LCM_DG_WAIT_FIRST);
    put(6'h00, 0, 0);
  endtask
  task automatic t_disc;
    put(6'h01, 0, 0);
    wt(LCM_DG_WAIT_SECOND);
    wt(LCM_ERR_DISCREPANCY);
    chk("disc timer", 16'h0008, tq[0]);
    put(6'h00, 0, 1);
    wt(LCM_DG_WAIT_FIRST);
    put(6'h00, 0, 0);
    en = 0;
    wt(LCM_DG_NO_ENABLE);
  endtask
  // Startup fault at enable, then the startup test
  task automatic t_enable;
    put(6'h03, 0, 1);
    en = 1;
    wt(LCM_ERR_STARTUP);
    put(6'h00, 0, 0);
    en = 0;
    wt(LCM_DG_NO_ENABLE);
    put(6'h03, 0, 0);
    stup = 1;
    en = 1;
    wt(LCM_DG_STARTUP_TEST);
    put(6'h00, 0, 0);
    wt(LCM_DG_WAIT_FIRST);
  endtask
  // Automatic start through order, override and muting faults
  task automatic t_auto;
    put(6'h03, 0, 0);
    stup = 0;
    smode = LCM_AUTO_START_MODE;
    wt(LCM_DG_CLEAR);
    chk("qs auto", 1, qs);
    put(6'h0B, 0, 0);
    sens_mode = LCM_TWO_SENSOR_SERIAL;
    wt(LCM_ERR_ORDER);
    put(6'h0B, 1, 0);
    wt(LCM_DG_OVERRIDE);
    put(6'h0B, 0, 0);
    wt(LCM_ERR_CLEARING);
    put(6'h03, 0, 1);
    wt(LCM_DG_CLEAR);
    put(6'h13, 0, 0);
    sens_mode = LCM_FOUR_SENSOR_SEQUENTIAL;
    wt(LCM_ERR_ORDER);
    put(6'h03, 0, 1);
    wt(LCM_DG_CLEAR);
    put(6'h0F, 0, 0);
    sens_mode = LCM_TWO_SENSOR_PARALLEL;
    mtime = 16'h0004;
    wt(LCM_ERR_MUTING);
    chk("qs", 0, qs);
    chk("mute timer", mtime, tq[1]);
    put(6'h0F, 1, 0);
    wt(LCM_DG_OVERRIDE);
    put(6'h03, 0, 0);
    wt(LCM_DG_CLEAR);
    put(6'h33, 0, 0);
    sens_mode = LCM_FOUR_SENSOR_PARALLEL;
    mtime = 16'h0000;
    wt(LCM_DG_MUTE_ACTIVE);
    put(6'h00, 0, 0);
    wt(LCM_ERR_NOT_FREE);
    put(6'h03, 0, 1);
    wt(LCM_DG_CLEAR);
    put(6'h01, 0, 0);
    wt(LCM_DG_ONE_OPEN);
    put(6'h03, 0, 0);
    wt(LCM_ERR_ONE_CHANNEL);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1;
    t_start();
    t_mute();
    t_sync_ovr();
    t_disc();
    t_enable();
    t_auto();
    final_report();
  end
endmodule
`default_nettype wire
